// ### pkg/epdhsc_pkg.sv
// Purpose: shared constants, command codes and types of the serial command port
// Assumes: core clock of 100 MHz
// Notes: command codes of busy-flag commands that are not printed nearby are plain defaults
package epdhsc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_TIME_NS = 1000000;
	// strictly longer than the init time, so one cycle more
	localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS + 1;
	localparam int TSENSE_CYCLES = 32;
	localparam int OP_CYCLES = 64;

	// ----------------------------------------------------------------
	// serial framing
	// ----------------------------------------------------------------
	localparam logic [3:0] UNIT_BITS_3W = 4'h9;
	localparam logic [3:0] UNIT_BITS_4W = 4'h8;
	localparam logic [2:0] MSB_IDX = 3'h7;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] POWER_OFF_CMD = 8'h02;
	localparam logic [7:0] POWER_ON_CMD = 8'h04;
	localparam logic [7:0] POWER_MEASURE_CMD = 8'h05;
	localparam logic [7:0] DEEP_SLEEP_CMD = 8'h07;
	localparam logic [7:0] DATA_STOP_CMD = 8'h11;
	localparam logic [7:0] DISPLAY_REFRESH_CMD = 8'h12;
	localparam logic [7:0] TEMP_SENSE_CMD = 8'h40;
	localparam logic [7:0] LOW_POWER_DETECT_CMD = 8'h51;
	localparam logic [7:0] CHIP_VERSION_READ_CMD = 8'h70;
	localparam logic [7:0] STATUS_READ_CMD = 8'h71;
	localparam logic [7:0] AUTO_VCOM_MEASURE_CMD = 8'h80;
	localparam logic [7:0] VCOM_VALUE_READ_CMD = 8'h81;
	localparam logic [7:0] OTP_PROGRAM_CMD = 8'ha1;
	localparam logic [7:0] OTP_READ_CMD = 8'ha2;
	localparam logic [7:0] FORCE_TEMP_CMD = 8'he5;

	// ----------------------------------------------------------------
	// registers and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] FORCED_TEMP_VALUE_OFS = 8'he5;
	localparam logic [7:0] FORCED_TEMP_RST = 8'h00;
	localparam logic [3:0] FORCED_TEMP_PARAMS = 4'h1;
	localparam logic [7:0] OTP_DUMMY_BYTE = 8'h00;
	localparam int ST_BUSY_N_BIT = 0;
	localparam int ST_PWR_OFF_BIT = 1;
	localparam int ST_PWR_ON_BIT = 2;
	localparam int OTP_ADDR_W = 12;

	typedef enum logic [1:0]
	{
		EPDHSC_IDLE = 2'b00,
		EPDHSC_TSENSE = 2'b01,
		EPDHSC_OP = 2'b11
	} epdhsc_busy_t;

	function automatic logic epdhsc_is_busy_cmd(input logic [7:0] c);
		return (c == POWER_OFF_CMD) || (c == POWER_ON_CMD) || (c == POWER_MEASURE_CMD) ||
			(c == DEEP_SLEEP_CMD) || (c == DATA_STOP_CMD) || (c == DISPLAY_REFRESH_CMD) ||
			(c == TEMP_SENSE_CMD) || (c == LOW_POWER_DETECT_CMD) ||
			(c == AUTO_VCOM_MEASURE_CMD) || (c == OTP_PROGRAM_CMD);
	endfunction : epdhsc_is_busy_cmd

	function automatic logic epdhsc_is_refresh_cmd(input logic [7:0] c);
		return (c == DATA_STOP_CMD) || (c == DISPLAY_REFRESH_CMD);
	endfunction : epdhsc_is_refresh_cmd

	// reads allowed during refresh; the otp read is a read but not allowed then
	function automatic logic epdhsc_refresh_ok(input logic [7:0] c);
		return (c == CHIP_VERSION_READ_CMD) || (c == STATUS_READ_CMD) || (c == VCOM_VALUE_READ_CMD);
	endfunction : epdhsc_refresh_ok

	function automatic logic epdhsc_is_read_cmd(input logic [7:0] c);
		return epdhsc_refresh_ok(c) || (c == OTP_READ_CMD);
	endfunction : epdhsc_is_read_cmd

endpackage : epdhsc_pkg

// ### pkg/epdhsc_link_if.sv
// Purpose: carrier between the serial-clock shifter and the core
// Assumes: read-side signals are held still while a frame runs
// Notes: unit_tgl flips once per received unit; byte and dc are stable around it
`timescale 1ns/10ps
interface epdhsc_link_if;
	logic mode3w;
	logic rd_mode;
	logic [7:0] rd_byte;
	logic unit_tgl;
	logic [7:0] unit_byte;
	logic unit_dc;

	modport link
	(
		input mode3w,
		input rd_mode,
		input rd_byte,
		output unit_tgl,
		output unit_byte,
		output unit_dc
	);

	modport core
	(
		output mode3w,
		output rd_mode,
		output rd_byte,
		input unit_tgl,
		input unit_byte,
		input unit_dc
	);
endinterface : epdhsc_link_if

// ### design/epdhsc_sync.sv
// Purpose: two-flop synchroniser for levels and toggles
// Assumes: each bit is independent
// Notes: nothing may look at the first stage
`timescale 1ns/10ps
module epdhsc_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule : epdhsc_sync

// ### design/epdhsc_shifter.sv
// Purpose: serial-clock side of the command port, 3-wire and 4-wire
// Assumes: serial clock only runs while chip select is low
// Notes: bit counter is held clear by chip select high
`timescale 1ns/10ps
module epdhsc_shifter
	import epdhsc_pkg::*;
(
	input wire logic serial_clk_i,
	input wire logic rst_i,
	input wire logic chip_select_bar_i,
	input wire logic sda_i,
	input wire logic cmd_data_select_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	epdhsc_link_if.link lnk
);
	logic frame_rst;
	logic [3:0] cnt_q;
	logic [6:0] shift_q;
	logic first_q;
	logic last_bit;
	logic [2:0] idx_q;
	logic drv_q;

	// ----------------------------------------------------------------
	// input side
	// ----------------------------------------------------------------
	assign frame_rst = rst_i | chip_select_bar_i;
	assign last_bit = lnk.mode3w ? (cnt_q == UNIT_BITS_3W - 4'h1) : (cnt_q == UNIT_BITS_4W - 4'h1);

	always_ff @(posedge serial_clk_i or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			cnt_q <= '0;
			shift_q <= '0;
			first_q <= 1'b0;
		end
		else
		begin
			cnt_q <= last_bit ? 4'h0 : cnt_q + 4'h1;
			if (lnk.mode3w && cnt_q == 4'h0)
				first_q <= sda_i;
			else
				shift_q <= {shift_q[5:0], sda_i};
		end
	end

	// unit capture survives chip select so the toggle keeps its phase
	always_ff @(posedge serial_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lnk.unit_tgl <= 1'b0;
			lnk.unit_byte <= '0;
			lnk.unit_dc <= 1'b0;
		end
		else if (!chip_select_bar_i && last_bit)
		begin
			lnk.unit_tgl <= ~lnk.unit_tgl;
			lnk.unit_byte <= {shift_q, sda_i};
			lnk.unit_dc <= lnk.mode3w ? first_q : cmd_data_select_i;
		end
	end

	// ----------------------------------------------------------------
	// output side, changes on the falling edge
	// ----------------------------------------------------------------
	always_ff @(negedge serial_clk_i or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			idx_q <= MSB_IDX;
			drv_q <= 1'b0;
		end
		else if (lnk.mode3w)
		begin
			idx_q <= 3'(UNIT_BITS_4W - cnt_q);
			drv_q <= first_q && lnk.rd_mode && cnt_q != 4'h0;
		end
		else
		begin
			idx_q <= 3'(MSB_IDX - cnt_q[2:0]);
			drv_q <= 1'b0;
		end
	end

	// 4-wire must drive before any clock edge, so its enable follows the pins
	assign sda_o = lnk.rd_byte[idx_q];
	assign sda_oe_n_o = chip_select_bar_i |
		~(lnk.mode3w ? drv_q : (cmd_data_select_i & lnk.rd_mode));
endmodule : epdhsc_shifter

// ### design/epdhsc_top.sv
// Purpose: host serial command port of an e-paper driver
// Assumes: ref_clk_i at 100 MHz; serial clock is a separate domain
// Notes: internal operations are modelled by cycle counts; busy_n_o follows them
`timescale 1ns/10ps

// Summary of operation
// - sample rising edge, msb first, bytes
// - shift only while chip select low
// - keep defined parameters, drop surplus bytes
// - strap high 3-wire, low 4-wire
// - 3-wire units are nine bits, flag first
// - chip select high clears bit counter
// - 3-wire read drives msb after first fall
// - 4-wire select pin marks each byte
// - 4-wire read drives msb after select falls
// - otp read returns one dummy byte first
// - ignore commands for over 1 ms after reset
// - busy low during internal operations
// - only listed commands assert busy
// - refresh allows only three read commands
// - deep sleep until reset pin falls
// - force temperature command stores one byte
// - power on senses temperature before booster
// - copy table after refresh when source zero
// - status read shows busy, power flags
module epdhsc_top
	import epdhsc_pkg::*;
#(
	parameter int INIT_CNT = INIT_CYCLES,
	parameter int TSENSE_CNT = TSENSE_CYCLES,
	parameter int OP_CNT = OP_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic serial_clk_i,
	input wire logic chip_select_bar_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic cmd_data_select_i,
	input wire logic host_select_pin_i,
	input wire logic reset_bar_i,
	output logic busy_n_o,
	input wire logic lut_src_sel_i,
	input wire logic [7:0] lut_rev_i,
	input wire logic [5:0] vcom_value_i,
	input wire logic [7:0] otp_data_i,
	output logic [OTP_ADDR_W-1:0] otp_addr_o,
	output logic [7:0] forced_temp_value_o,
	output logic temp_sense_o,
	output logic booster_en_o,
	output logic lut_copy_o,
	output logic deep_sleep_o,
	output logic cmd_invalid_o
);
	localparam int INIT_W = $clog2(INIT_CNT + 1);
	localparam int OPC_W = $clog2(OP_CNT + TSENSE_CNT + 1);

	epdhsc_link_if lnk ();

	logic pin_run_s;
	logic strap_s;
	logic tgl_s;
	logic tgl_d_q;
	logic unit_evt;
	logic init_q;
	logic [INIT_W-1:0] init_cnt_q;
	logic mode3w_q;
	logic sleep_q;
	logic accept;
	logic is_cmd;
	logic is_data;
	logic cmd_ok;
	logic cur_valid_q;
	logic [7:0] cur_cmd_q;
	logic [3:0] pidx_q;
	logic rd_mode;
	logic rd_take;
	logic [7:0] rd_byte_q;
	logic otp_dummy_q;
	logic [7:0] status_byte;
	epdhsc_busy_t st_q;
	logic [OPC_W-1:0] op_cnt_q;
	logic [7:0] op_cmd_q;
	logic refresh_q;
	logic op_start;
	logic ts_done;
	logic op_done;

	// ----------------------------------------------------------------
	// link domain and crossings
	// ----------------------------------------------------------------
	epdhsc_shifter i_epdhsc_shifter (
		.serial_clk_i(serial_clk_i),
		.rst_i(rst_i),
		.chip_select_bar_i(chip_select_bar_i),
		.sda_i(sda_i),
		.cmd_data_select_i(cmd_data_select_i),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.lnk(lnk.link)
	);

	epdhsc_sync #(
		.W(3)
	) i_epdhsc_sync (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i({reset_bar_i, host_select_pin_i, lnk.unit_tgl}),
		.q_o({pin_run_s, strap_s, tgl_s})
	);

	// unit byte and flag were written on the same serial clock edge as the toggle and hold until the next unit
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			tgl_d_q <= 1'b0;
		else
			tgl_d_q <= tgl_s;
	end

	assign unit_evt = tgl_s ^ tgl_d_q;

	// ----------------------------------------------------------------
	// reset pin, init window, strap
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			init_q <= 1'b1;
			init_cnt_q <= '0;
		end
		else if (!pin_run_s)
		begin
			init_q <= 1'b1;
			init_cnt_q <= '0;
		end
		else if (init_q)
		begin
			if (init_cnt_q == INIT_W'(INIT_CNT - 1))
				init_q <= 1'b0;
			else
				init_cnt_q <= init_cnt_q + 1'b1;
		end
	end

	// strap is only trusted while the device sits in reset or init
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			mode3w_q <= 1'b0;
		else if (init_q)
			mode3w_q <= strap_s;
	end

	assign lnk.mode3w = mode3w_q;

	// ----------------------------------------------------------------
	// command and parameter decode
	// ----------------------------------------------------------------
	assign accept = unit_evt && !init_q && !sleep_q && pin_run_s;
	assign is_cmd = accept && !lnk.unit_dc;
	assign is_data = accept && lnk.unit_dc;
	assign cmd_ok = !refresh_q || epdhsc_refresh_ok(lnk.unit_byte);
	assign rd_mode = cur_valid_q && epdhsc_is_read_cmd(cur_cmd_q);
	assign rd_take = is_data && rd_mode;

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cur_valid_q <= 1'b0;
			cur_cmd_q <= '0;
			pidx_q <= '0;
		end
		else if (!pin_run_s)
			cur_valid_q <= 1'b0;
		else if (is_cmd)
		begin
			cur_valid_q <= cmd_ok;
			cur_cmd_q <= lnk.unit_byte;
			pidx_q <= '0;
		end
		else if (is_data && !rd_mode && pidx_q != 4'hf)
			pidx_q <= pidx_q + 4'h1;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cmd_invalid_o <= 1'b0;
		else
			cmd_invalid_o <= is_cmd && !cmd_ok;
	end

	// surplus parameter bytes fall through without effect
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			forced_temp_value_o <= FORCED_TEMP_RST;
		else if (!pin_run_s)
			forced_temp_value_o <= FORCED_TEMP_RST;
		else if (is_data && cur_valid_q && cur_cmd_q == FORCE_TEMP_CMD && pidx_q < FORCED_TEMP_PARAMS)
			forced_temp_value_o <= lnk.unit_byte;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb
	begin
		status_byte = '0;
		status_byte[ST_BUSY_N_BIT] = busy_n_o;
		status_byte[ST_PWR_OFF_BIT] = !booster_en_o;
		status_byte[ST_PWR_ON_BIT] = booster_en_o;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			otp_dummy_q <= 1'b1;
			otp_addr_o <= '0;
		end
		else if (is_cmd && lnk.unit_byte == OTP_READ_CMD)
		begin
			otp_dummy_q <= 1'b1;
			otp_addr_o <= '0;
		end
		else if (rd_take && cur_cmd_q == OTP_READ_CMD)
		begin
			if (otp_dummy_q)
				otp_dummy_q <= 1'b0;
			else
				otp_addr_o <= otp_addr_o + 1'b1;
		end
	end

	// held still during a frame; refreshed within a few cycles after each unit
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_byte_q <= '0;
		else if (cur_cmd_q == CHIP_VERSION_READ_CMD)
			rd_byte_q <= lut_rev_i;
		else if (cur_cmd_q == STATUS_READ_CMD)
			rd_byte_q <= status_byte;
		else if (cur_cmd_q == VCOM_VALUE_READ_CMD)
			rd_byte_q <= {2'b00, vcom_value_i};
		else if (cur_cmd_q == OTP_READ_CMD)
			rd_byte_q <= otp_dummy_q ? OTP_DUMMY_BYTE : otp_data_i;
		else
			rd_byte_q <= '0;
	end

	assign lnk.rd_mode = rd_mode;
	assign lnk.rd_byte = rd_byte_q;

	// ----------------------------------------------------------------
	// internal operation sequencer
	// ----------------------------------------------------------------
	// a flagged command arriving while busy is recorded but starts nothing
	assign op_start = is_cmd && cmd_ok && epdhsc_is_busy_cmd(lnk.unit_byte) && st_q == EPDHSC_IDLE;
	assign ts_done = st_q == EPDHSC_TSENSE && op_cnt_q == OPC_W'(TSENSE_CNT - 1);
	assign op_done = st_q == EPDHSC_OP && op_cnt_q == OPC_W'(OP_CNT - 1);

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_q <= EPDHSC_IDLE;
			op_cnt_q <= '0;
			op_cmd_q <= '0;
		end
		else if (!pin_run_s)
			st_q <= EPDHSC_IDLE;
		else
		begin
			case (st_q)
				EPDHSC_IDLE:
				begin
					op_cnt_q <= '0;
					if (op_start)
					begin
						op_cmd_q <= lnk.unit_byte;
						st_q <= (lnk.unit_byte == POWER_ON_CMD) ? EPDHSC_TSENSE : EPDHSC_OP;
					end
				end
				EPDHSC_TSENSE:
				begin
					op_cnt_q <= ts_done ? '0 : op_cnt_q + 1'b1;
					if (ts_done)
						st_q <= EPDHSC_OP;
				end
				EPDHSC_OP:
				begin
					op_cnt_q <= op_cnt_q + 1'b1;
					if (op_done)
						st_q <= EPDHSC_IDLE;
				end
				default:
					st_q <= EPDHSC_IDLE;
			endcase
		end
	end

	assign busy_n_o = (st_q == EPDHSC_IDLE) && !init_q;
	assign temp_sense_o = st_q == EPDHSC_TSENSE || (st_q == EPDHSC_OP && op_cmd_q == TEMP_SENSE_CMD);

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			refresh_q <= 1'b0;
		else if (!pin_run_s || op_done)
			refresh_q <= 1'b0;
		else if (op_start)
			refresh_q <= epdhsc_is_refresh_cmd(lnk.unit_byte);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			booster_en_o <= 1'b0;
		else if (!pin_run_s)
			booster_en_o <= 1'b0;
		else if (ts_done)
			booster_en_o <= 1'b1;
		else if (op_done && (op_cmd_q == POWER_OFF_CMD || op_cmd_q == DEEP_SLEEP_CMD))
			booster_en_o <= 1'b0;
	end

	// only the reset pin going low wakes the device
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			sleep_q <= 1'b0;
		else if (!pin_run_s)
			sleep_q <= 1'b0;
		else if (op_done && op_cmd_q == DEEP_SLEEP_CMD)
			sleep_q <= 1'b1;
	end

	assign deep_sleep_o = sleep_q;

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			lut_copy_o <= 1'b0;
		else
			lut_copy_o <= op_done && epdhsc_is_refresh_cmd(op_cmd_q) && !lut_src_sel_i;
	end

endmodule : epdhsc_top

// ### testbench/epdhsc_checker.sv
// Purpose: port-level assertions for the serial command port
// Assumes: bound to epdhsc_top, one ref clock domain
// Notes: serial-side rules are checked by the bench
`timescale 1ns/10ps
module epdhsc_checker
	import epdhsc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic chip_select_bar_i,
	input wire logic sda_oe_n_o,
	input wire logic reset_bar_i,
	input wire logic busy_n_o,
	input wire logic lut_src_sel_i,
	input wire logic lut_copy_o,
	input wire logic cmd_invalid_o,
	input wire logic [7:0] forced_temp_value_o,
	input wire logic deep_sleep_o,
	input wire logic booster_en_o,
	input wire logic temp_sense_o
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	idle_release_a: assert property (chip_select_bar_i |-> sda_oe_n_o)
		else $error("sda driven while deselected");
	init_busy_a: assert property ($rose(reset_bar_i) |-> !busy_n_o [*8])
		else $error("ready too early after reset pin");
	sense_busy_a: assert property (temp_sense_o |-> !busy_n_o)
		else $error("sensing while not busy");
	boost_order_a: assert property ($rose(booster_en_o) |-> $past(temp_sense_o))
		else $error("booster without prior sensing");
	copy_pulse_a: assert property (lut_copy_o |-> !$past(lut_src_sel_i) ##1 !lut_copy_o)
		else $error("bad table copy pulse");
	refuse_busy_a: assert property (cmd_invalid_o |-> !$past(busy_n_o))
		else $error("refusal outside refresh");
	refuse_pulse_a: assert property (cmd_invalid_o |=> !cmd_invalid_o)
		else $error("refusal pulse too long");
	temp_clear_a: assert property (!reset_bar_i [*5] |-> forced_temp_value_o == FORCED_TEMP_RST)
		else $error("forced temperature not cleared");
	sleep_hold_a: assert property (deep_sleep_o && reset_bar_i |=> deep_sleep_o)
		else $error("left sleep without reset pin");
	sleep_exit_a: assert property (!reset_bar_i [*5] |-> !deep_sleep_o && !booster_en_o)
		else $error("sleep kept under reset pin");

	cover property ($rose(booster_en_o));
	cover property (cmd_invalid_o);
	cover property ($rose(deep_sleep_o));
endmodule : epdhsc_checker

bind epdhsc_top epdhsc_checker i_epdhsc_checker (.ref_clk_i, .rst_i, .chip_select_bar_i, .sda_oe_n_o,
	.reset_bar_i, .busy_n_o, .lut_src_sel_i, .lut_copy_o, .cmd_invalid_o, .forced_temp_value_o,
	.deep_sleep_o, .booster_en_o, .temp_sense_o);

// ### testbench/epdhsc_host_model.sv
// Purpose: host controller driving the serial command pins
// Assumes: 64 ns serial clock, idle low, runs only inside frames
// Notes: sda_w_i is the resolved data line
`timescale 1ns/10ps
module epdhsc_host_model
(
	output logic serial_clk_o,
	output logic chip_select_bar_o,
	output logic sda_o,
	output logic cmd_data_select_o,
	input wire logic mode3w_i,
	input wire logic sda_w_i
);
	initial
	begin
		serial_clk_o = 1'b0;
		chip_select_bar_o = 1'b1;
		sda_o = 1'b0;
		cmd_data_select_o = 1'b0;
	end

	// one whole unit; chip select goes high after it so the counter restarts
	task automatic xfer(input logic dc, input logic [7:0] wr, output logic [7:0] rd);
		logic [8:0] bits;
		int lo;
		bits = mode3w_i ? {dc, wr} : {wr, 1'b0};
		lo = mode3w_i ? 0 : 1;
		rd = 8'h00;
		#3;
		cmd_data_select_o = mode3w_i ? 1'b0 : dc;
		// a single chip here, so every command reaches it on this one select
		chip_select_bar_o = 1'b0;
		#40;
		for (int i = 8; i >= lo; i--)
		begin
			sda_o = bits[i];
			#32 serial_clk_o = 1'b1;
			rd = {rd[6:0], sda_w_i};
			#32 serial_clk_o = 1'b0;
		end
		#40 chip_select_bar_o = 1'b1;
		sda_o = ~sda_o;
		#120;
	endtask : xfer

	// broken unit, abandoned by raising chip select
	task automatic partial(input int n);
		chip_select_bar_o = 1'b0;
		sda_o = 1'b1;
		#40;
		repeat (n)
		begin
			#32 serial_clk_o = 1'b1;
			#32 serial_clk_o = 1'b0;
		end
		#40 chip_select_bar_o = 1'b1;
		sda_o = 1'b0;
		#120;
	endtask : partial
endmodule : epdhsc_host_model

// ### testbench/epdhsc_top_tb.sv
// Purpose: self-checking bench of the serial command port
// Assumes: shortened init count, lengthened operation count
// Notes: bench inputs change on the falling ref clock edge
`timescale 1ns/10ps
module epdhsc_top_tb;
	import epdhsc_pkg::*;
	logic ref_clk, rst, reset_bar, host_sel, lut_src_sel, sda_o, sda_oe_n, busy_n;
	logic temp_sense, booster, lut_copy, deep_sleep, cmd_inv, sclk, chip_sel_n, host_sda, dc, sda_w;
	logic [7:0] lut_rev, otp_data, forced_temp, rd;
	logic [5:0] vcom;
	logic [OTP_ADDR_W-1:0] otp_addr;
	int fail_count = 0;
	int samples_checked = 0;
	int inv_seen = 0;
	int copy_seen = 0;
	logic [7:0] flag_cmds [9] = '{POWER_ON_CMD, POWER_OFF_CMD, POWER_MEASURE_CMD, DATA_STOP_CMD,
		DISPLAY_REFRESH_CMD, TEMP_SENSE_CMD, LOW_POWER_DETECT_CMD, AUTO_VCOM_MEASURE_CMD, OTP_PROGRAM_CMD};

	assign sda_w = sda_oe_n ? host_sda : sda_o;

	epdhsc_top #(.INIT_CNT(200), .TSENSE_CNT(32), .OP_CNT(400)) i_epdhsc_top
	(
		.ref_clk_i(ref_clk), .rst_i(rst), .serial_clk_i(sclk), .chip_select_bar_i(chip_sel_n), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .cmd_data_select_i(dc), .host_select_pin_i(host_sel),
		.reset_bar_i(reset_bar), .busy_n_o(busy_n), .lut_src_sel_i(lut_src_sel), .lut_rev_i(lut_rev),
		.vcom_value_i(vcom), .otp_data_i(otp_data), .otp_addr_o(otp_addr), .forced_temp_value_o(forced_temp),
		.temp_sense_o(temp_sense), .booster_en_o(booster), .lut_copy_o(lut_copy),
		.deep_sleep_o(deep_sleep), .cmd_invalid_o(cmd_inv)
	);

	epdhsc_host_model i_epdhsc_host_model
	(
		.serial_clk_o(sclk), .chip_select_bar_o(chip_sel_n), .sda_o(host_sda), .cmd_data_select_o(dc),
		.mode3w_i(host_sel), .sda_w_i(sda_w)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// pulses are counted so a check need not hit their exact cycle; sampled away from the launch edge
	always @(negedge ref_clk)
	begin
		if (cmd_inv === 1'b1)
			inv_seen++;
		if (lut_copy === 1'b1)
			copy_seen++;
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : chk

	task automatic wr(input logic d, input logic [7:0] b);
		logic [7:0] unused;
		i_epdhsc_host_model.xfer(d, b, unused);
		@(negedge ref_clk);
	endtask : wr

	task automatic rdb(input logic [7:0] c, output logic [7:0] v);
		wr(1'b0, c);
		i_epdhsc_host_model.xfer(1'b1, 8'h00, v);
		@(negedge ref_clk);
	endtask : rdb

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_n !== 1'b1 && n < 5000)
		begin
			@(negedge ref_clk);
			n++;
		end
		repeat (3) @(negedge ref_clk);
		chk("idle", 8'h01, {7'h0, busy_n});
	endtask : wait_idle

	task automatic pin_reset();
		@(negedge ref_clk);
		reset_bar = 1'b0;
		repeat (6) @(negedge ref_clk);
		reset_bar = 1'b1;
	endtask : pin_reset

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	initial
	begin
		#300000;
		fail_count++;
		$display("BAD watchdog expected end seen timeout");
		stop_test();
	end

	initial
	begin
		rst = 1'b1;
		reset_bar = 1'b0;
		host_sel = 1'b0;
		lut_src_sel = 1'b0;
		lut_rev = 8'h3c;
		vcom = 6'h2b;
		otp_data = 8'h96;
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		reset_bar = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk("init_busy", 8'h00, {7'h0, busy_n});
		wr(1'b0, FORCE_TEMP_CMD);
		wr(1'b1, 8'h77);
		wait_idle();
		chk("temp_init", FORCED_TEMP_RST, forced_temp);
		wr(1'b0, FORCE_TEMP_CMD);
		wr(1'b1, 8'h5a);
		wr(1'b1, 8'h33);
		chk("temp_set", 8'h5a, forced_temp);
		wr(1'b0, FORCE_TEMP_CMD);
		i_epdhsc_host_model.partial(3);
		wr(1'b1, 8'hc3);
		chk("temp_part", 8'hc3, forced_temp);
		rdb(CHIP_VERSION_READ_CMD, rd);
		chk("version", 8'h3c, rd);
		rdb(VCOM_VALUE_READ_CMD, rd);
		chk("vcom", {2'b00, vcom}, rd);
		rdb(STATUS_READ_CMD, rd);
		chk("status_idle", 8'h01, rd & 8'h01);
		rdb(OTP_READ_CMD, rd);
		chk("otp_dummy", OTP_DUMMY_BYTE, rd);
		i_epdhsc_host_model.xfer(1'b1, 8'h00, rd);
		chk("otp_data", 8'h96, rd);
		@(negedge ref_clk);
		chk("otp_addr", 8'h01, otp_addr[7:0]);
		wr(1'b0, 8'h61);
		chk("busy_plain", 8'h01, {7'h0, busy_n});
		foreach (flag_cmds[k])
		begin
			wr(1'b0, flag_cmds[k]);
			chk("busy_flag", 8'h00, {7'h0, busy_n});
			if (k == 0)
				chk("sense", 8'h01, {7'h0, temp_sense});
			wait_idle();
			if (k == 0)
				chk("booster", 8'h01, {7'h0, booster});
		end
		chk("copies", 8'h02, copy_seen[7:0]);
		wr(1'b0, DISPLAY_REFRESH_CMD);
		wr(1'b0, FORCE_TEMP_CMD);
		wr(1'b1, 8'h44);
		rdb(STATUS_READ_CMD, rd);
		chk("status_busy", 8'h00, rd & 8'h01);
		chk("refused", 8'h01, inv_seen[7:0]);
		wait_idle();
		chk("temp_kept", 8'hc3, forced_temp);
		@(negedge ref_clk);
		lut_src_sel = 1'b1;
		wr(1'b0, DATA_STOP_CMD);
		wait_idle();
		chk("copies_off", 8'h03, copy_seen[7:0]);
		@(negedge ref_clk);
		host_sel = 1'b1;
		pin_reset();
		wait_idle();
		wr(1'b0, FORCE_TEMP_CMD);
		wr(1'b1, 8'ha5);
		chk("temp_3w", 8'ha5, forced_temp);
		rdb(CHIP_VERSION_READ_CMD, rd);
		chk("version_3w", 8'h3c, rd);
		wr(1'b0, DEEP_SLEEP_CMD);
		wait_idle();
		chk("sleep", 8'h01, {7'h0, deep_sleep});
		wr(1'b0, FORCE_TEMP_CMD);
		wr(1'b1, 8'h11);
		chk("temp_sleep", 8'ha5, forced_temp);
		pin_reset();
		chk("wake", 8'h00, {7'h0, deep_sleep});
		stop_test();
	end
endmodule : epdhsc_top_tb
